/* common/irq_pkg.sv */
package irq_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00; // interrupt_control_reg
  localparam logic [7:0] OFF_STATUS = 8'h01; // interrupt_status_reg
  localparam logic [7:0] OFF_KEY_WAKEUP_INPUT_ENABLES  = 8'h02; // key_wakeup_input_enables
  localparam logic [7:0] OFF_SRCEN  = 8'h03; // peripheral source enables
  localparam logic [7:0] OFF_CORE   = 8'h04; // mask bit and stack pointer
  localparam logic [7:0] OFF_PORTC  = 8'h05; // request pin levels

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_EN_A   = 7;
  localparam int CTRL_EN_B   = 6;
  localparam int CTRL_EN_KW  = 4;
  localparam int CTRL_SEL_A  = 3;
  localparam int CTRL_SEL_B  = 2;
  localparam int STAT_FLAG_A = 7;
  localparam int STAT_FLAG_B = 6;
  localparam int STAT_KW     = 4;
  localparam int STAT_CLR_A  = 3;
  localparam int STAT_CLR_B  = 2;
  localparam int STAT_CLR_KW = 0;
  localparam int CORE_IMASK  = 7;
  localparam int PORTC_BIT7  = 7;
  localparam int PORTC_BIT6  = 6;

  // ------------------------------------------------------------
  // Vectors and stack
  // ------------------------------------------------------------
  localparam logic [15:0] VEC_BASE_USER  = 16'hfff0;
  localparam logic [15:0] VEC_BASE_CHECK = 16'hffe0;
  localparam logic [2:0]  VEC_TIMEBASE   = 3'h0;
  localparam logic [2:0]  VEC_SERIAL     = 3'h1;
  localparam logic [2:0]  VEC_TIMER_B    = 3'h2;
  localparam logic [2:0]  VEC_TIMER_A    = 3'h3;
  localparam logic [2:0]  VEC_KEY        = 3'h4;
  localparam logic [2:0]  VEC_EXT        = 3'h5;
  localparam logic [2:0]  VEC_SWI        = 3'h6;
  localparam logic [2:0]  VEC_RESET      = 3'h7;
  localparam logic [9:0]  SP_UPPER       = 10'b0000000011;
  localparam logic [5:0]  SP_TOP         = 6'h3f;
  localparam logic [2:0]  FRAME_LAST     = 3'h4; // five bytes, 0..4
  localparam logic [2:0]  SETTLE_CNT     = 3'h2; // strap synchroniser depth
  localparam logic [2:0]  CCR_UNUSED     = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PUSH   = 3'b001,
    ST_START  = 3'b011,
    ST_VEC_HI = 3'b010,
    ST_VEC_LO = 3'b110,
    ST_LOAD   = 3'b111
  } state_type;

endpackage : irq_pkg

/* core/interrupt_priority_stacking.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE_01: User vectors at top, self-check at FFE0
// RULE_02: All resets use top vector, unmaskable
// RULE_03: Software trap uses second vector, unmaskable
// RULE_04: Both request pins share priority-2 vector
// RULE_05: Key-wakeup has own priority-3 vector
// RULE_06: Timer A priority 4, timer B 5
// RULE_07: Serial priority 6, timebase lowest vector
// RULE_08: Any reset sets the global mask
// RULE_09: Mask set only after context push
// RULE_10: Fixed hardware priority among pending sources
// RULE_11: Per-source masks plus global class mask
// RULE_12: Masked request stays latched until serviced
// RULE_13: Trap blocks hardware sources until handler starts
// RULE_14: Five-byte frame, low PC byte first
// RULE_15: Stack pointer top on reset, push/pull
// RULE_16: Six-bit pointer, fixed upper bits, wraps
// RULE_17: Select bit: edge only or edge/level
// RULE_18: Software clears flag before enabling it
// RULE_19: Pins readable as port C; branch tests A
// RULE_20: Enabled key falling edge sets wakeup flag
// RULE_21: Per-key latch, all cleared together
// RULE_22: Pin enables act one instruction late
// RULE_23: Request raised only when flag and enable
// RULE_24: Write one clears request flag, reads zero
// RULE_25: Write one clears key-wakeup flag
// RULE_26: Vector high byte at lower address
// RULE_27: Flags hold until cleared or reset
module interrupt_priority_stacking
  import irq_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // Pins
  input  wire logic        EXT_REQUEST_A_N,
  input  wire logic        EXT_REQUEST_B_N,
  input  wire logic [7:0]  KEY_WAKEUP_N,
  input  wire logic        EXT_RESET_N,
  input  wire logic        SELF_CHECK,
  // Peripheral sources
  input  wire logic [1:0]  PORT_C_LATCH,
  input  wire logic        WATCHDOG_TIMEOUT,
  input  wire logic        TIMER_A_OVERFLOW_IRQ,
  input  wire logic        TIMER_A_CAPTURE_IRQ,
  input  wire logic        TIMER_A_COMPARE_IRQ,
  input  wire logic        TIMER_B_IRQ,
  input  wire logic        TIMER_B_COMPARE_IRQ,
  input  wire logic        SERIAL_TRANSFER_IRQ,
  input  wire logic        TIMEBASE_IRQ,
  // Sequencer
  input  wire logic        INSTR_DONE,
  input  wire logic        SOFTWARE_TRAP,
  input  wire logic        STACK_PUSH,
  input  wire logic        STACK_PULL,
  input  wire logic        STACK_POINTER_RESET_INSTR,
  input  wire logic        IMASK_SET,
  input  wire logic        IMASK_CLEAR,
  input  wire logic [15:0] PC_IN,
  input  wire logic [7:0]  ACC_IN,
  input  wire logic [7:0]  INDEX_IN,
  input  wire logic [3:0]  CCR_FLAGS,
  output logic             BUSY,
  output logic             INT_PENDING,
  output logic             IMASK,
  output logic      [15:0] STACK_ADDR,
  output logic      [15:0] HANDLER_PC,
  output logic             HANDLER_VALID,
  output logic             EXT_A_LEVEL,
  output logic      [1:0]  PORT_C_LEVELS,
  // Memory port
  output logic      [15:0] MEM_ADDR,
  output logic      [7:0]  MEM_WDATA,
  output logic             MEM_WE,
  output logic             MEM_RD,
  input  wire logic [7:0]  MEM_RDATA
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    state_type   st;
    logic [2:0]  cnt;
    logic [5:0]  sp;
    logic        imask;
    logic [2:0]  vec;
    logic [7:0]  vec_hi;
    logic        flag_a;
    logic        flag_b;
    logic [7:0]  kw_latch;
    logic        en_a;
    logic        en_b;
    logic        en_kw;
    logic        sel_a;
    logic        sel_b;
    logic        eff_a;
    logic        eff_b;
    logic        eff_kw;
    logic [6:0]  src_en;
    logic [7:0]  key_wakeup_input_enables;
    logic        swi_blk;
    logic        first_wait;
    logic [2:0]  pa_s;
    logic [2:0]  pb_s;
    logic [7:0]  kw_s1;
    logic [7:0]  kw_s2;
    logic [7:0]  kw_s3;
    logic [1:0]  rp_s;
    logic [1:0]  sc_s;
    logic [15:0] ctx_pc;
    logic [7:0]  ctx_x;
    logic [7:0]  ctx_a;
    logic [7:0]  ctx_ccr;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        mem_we;
    logic        mem_rd;
    logic [7:0]  rdata;
    logic [15:0] handler;
    logic        handler_v;
  } core_state_type;

  // Request, key and reset pins idle high, so their synchronisers start high to avoid a false edge
  localparam core_state_type RESET_VAL = '{
    st: ST_START, sp: SP_TOP, imask: 1'b1, vec: VEC_RESET,
    pa_s: 3'h7, pb_s: 3'h7, kw_s1: 8'hff, kw_s2: 8'hff, kw_s3: 8'hff,
    rp_s: 2'h3, default: '0
  };

  core_state_type s;
  core_state_type n;

  logic       line_a;
  logic       line_b;
  logic       set_a;
  logic       set_b;
  logic [7:0] kw_fall;
  logic       kw_flag;
  logic       clr_a;
  logic       clr_b;
  logic       clr_kw;
  logic [5:0] cls;
  logic       hw_ok;
  logic       take_hw;
  logic       take_swi;
  logic       soft_rst;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic [15:0] vec_addr(input logic chk, input logic [2:0] idx, input logic lo);
    logic [15:0] base;
    base = chk ? VEC_BASE_CHECK : VEC_BASE_USER;                      // [RULE_01]
    return {base[15:4], idx, lo};                                     // [RULE_26]
  endfunction : vec_addr

  function automatic logic [2:0] top_src(input logic [5:0] c);
    logic [2:0] r;
    r = VEC_TIMEBASE;
    for (int k = 0; k < 6; k++) begin
      if (c[k]) begin
        r = 3'(k);                                                    // [RULE_10]
      end
    end
    return r;
  endfunction : top_src

  // ------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------
  // Port C output latch pulls the line low too, hence the flag caveat
  assign line_a   = s.pa_s[1] & PORT_C_LATCH[1];                      // [RULE_18]
  assign line_b   = s.pb_s[1] & PORT_C_LATCH[0];
  assign set_a    = (s.pa_s[2] & ~line_a) | (~s.sel_a & ~line_a);     // [RULE_17]
  assign set_b    = (s.pb_s[2] & ~line_b) | (~s.sel_b & ~line_b);     // [RULE_17]
  assign kw_fall  = s.kw_s3 & ~s.kw_s2 & s.key_wakeup_input_enables;                     // [RULE_20] [RULE_21]
  assign kw_flag  = |s.kw_latch;
  assign clr_a    = WR && ADDR == OFF_STATUS && WDATA[STAT_CLR_A];    // [RULE_24]
  assign clr_b    = WR && ADDR == OFF_STATUS && WDATA[STAT_CLR_B];    // [RULE_24]
  assign clr_kw   = WR && ADDR == OFF_STATUS && WDATA[STAT_CLR_KW];   // [RULE_25]
  assign soft_rst = ~s.rp_s[1] | WATCHDOG_TIMEOUT;                    // [RULE_02]

  always_comb begin
    cls[VEC_EXT]      = (s.flag_a & s.en_a & s.eff_a) |
                        (s.flag_b & s.en_b & s.eff_b);                // [RULE_04] [RULE_23] [RULE_22]
    cls[VEC_KEY]      = kw_flag & s.en_kw & s.eff_kw;                 // [RULE_05] [RULE_20]
    cls[VEC_TIMER_A]  = |({TIMER_A_COMPARE_IRQ, TIMER_A_CAPTURE_IRQ, TIMER_A_OVERFLOW_IRQ} &
                          s.src_en[2:0]);                             // [RULE_06]
    cls[VEC_TIMER_B]  = |({TIMER_B_COMPARE_IRQ, TIMER_B_IRQ} & s.src_en[4:3]); // [RULE_06]
    cls[VEC_SERIAL]   = SERIAL_TRANSFER_IRQ & s.src_en[5];            // [RULE_07]
    cls[VEC_TIMEBASE] = TIMEBASE_IRQ & s.src_en[6];                   // [RULE_07]
  end

  // Global class mask and the trap window both hold requests back
  assign hw_ok       = ~s.imask & ~s.swi_blk & (s.st == ST_IDLE);     // [RULE_11] [RULE_13]
  assign INT_PENDING = (|cls) & hw_ok;                                // [RULE_12]
  assign take_swi    = SOFTWARE_TRAP && s.st == ST_IDLE && !soft_rst; // [RULE_03]
  assign take_hw     = INSTR_DONE && INT_PENDING && !take_swi && !soft_rst;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n           = s;
    n.mem_we    = 1'b0;
    n.mem_rd    = 1'b0;
    n.handler_v = 1'b0;
    n.rdata     = '0;
    n.pa_s      = {line_a, s.pa_s[0], EXT_REQUEST_A_N};
    n.pb_s      = {line_b, s.pb_s[0], EXT_REQUEST_B_N};
    n.kw_s1     = KEY_WAKEUP_N;
    n.kw_s2     = s.kw_s1;
    n.kw_s3     = s.kw_s2;
    n.rp_s      = {s.rp_s[0], EXT_RESET_N};
    n.sc_s      = {s.sc_s[0], SELF_CHECK};
    // Set wins over a clear in the same cycle
    n.flag_a    = (s.flag_a & ~clr_a) | set_a;                        // [RULE_27] [RULE_12]
    n.flag_b    = (s.flag_b & ~clr_b) | set_b;                        // [RULE_27]
    n.kw_latch  = (s.kw_latch & ~{8{clr_kw}}) | kw_fall;              // [RULE_21] [RULE_25]

    if (WR) begin
      case (ADDR)
        OFF_CTRL: begin
          n.en_a  = WDATA[CTRL_EN_A];
          n.en_b  = WDATA[CTRL_EN_B];
          n.en_kw = WDATA[CTRL_EN_KW];
          n.sel_a = WDATA[CTRL_SEL_A];
          n.sel_b = WDATA[CTRL_SEL_B];
        end
        OFF_KEY_WAKEUP_INPUT_ENABLES: n.key_wakeup_input_enables  = WDATA;                                  // [RULE_20]
        OFF_SRCEN: n.src_en = WDATA[6:0];                             // [RULE_11]
        default: ;
      endcase
    end

    if (RD) begin
      case (ADDR)
        OFF_CTRL:   n.rdata = {s.en_a, s.en_b, 1'b0, s.en_kw, s.sel_a, s.sel_b, 2'b00};
        OFF_STATUS: n.rdata = {s.flag_a, s.flag_b, 1'b0, kw_flag, 4'h0}; // [RULE_24]
        OFF_KEY_WAKEUP_INPUT_ENABLES:  n.rdata = s.key_wakeup_input_enables;
        OFF_SRCEN:  n.rdata = {1'b0, s.src_en};
        OFF_CORE:   n.rdata = {s.imask, 1'b0, s.sp};
        OFF_PORTC:  n.rdata = {line_a, line_b, 6'h00};                // [RULE_19]
        default:    n.rdata = '0;
      endcase
    end

    // Enables for pin and key requests take hold one boundary late
    if (INSTR_DONE) begin
      n.eff_a  = s.en_a;                                              // [RULE_22]
      n.eff_b  = s.en_b;
      n.eff_kw = s.en_kw;
      if (s.first_wait) begin
        n.swi_blk    = 1'b0;                                          // [RULE_13]
        n.first_wait = 1'b0;
      end
    end

    if (IMASK_SET) begin
      n.imask = 1'b1;
    end else if (IMASK_CLEAR) begin
      n.imask = 1'b0;
    end

    if (STACK_POINTER_RESET_INSTR) begin
      n.sp = SP_TOP;                                                  // [RULE_15]
    end else if (STACK_PUSH) begin
      n.sp = s.sp - 6'h01;                                            // [RULE_15] [RULE_16]
    end else if (STACK_PULL) begin
      n.sp = s.sp + 6'h01;                                            // [RULE_15] [RULE_16]
    end

    case (s.st)
      ST_IDLE: begin
        if (take_swi || take_hw) begin
          n.st      = ST_PUSH;
          n.cnt     = '0;
          n.vec     = take_swi ? VEC_SWI : top_src(cls);              // [RULE_03] [RULE_10]
          n.swi_blk = take_swi;                                       // [RULE_13]
          n.ctx_pc  = PC_IN;
          n.ctx_x   = INDEX_IN;
          n.ctx_a   = ACC_IN;
          n.ctx_ccr = {CCR_UNUSED, CCR_FLAGS[3], s.imask, CCR_FLAGS[2:0]};
        end
      end
      ST_PUSH: begin
        n.mem_we   = 1'b1;
        n.mem_addr = {SP_UPPER, s.sp};                                // [RULE_16]
        n.sp       = s.sp - 6'h01;                                    // [RULE_14]
        n.cnt      = s.cnt + 3'h1;
        case (s.cnt)
          3'h0:    n.mem_wdata = s.ctx_pc[7:0];                       // [RULE_14]
          3'h1:    n.mem_wdata = s.ctx_pc[15:8];
          3'h2:    n.mem_wdata = s.ctx_x;
          3'h3:    n.mem_wdata = s.ctx_a;
          default: n.mem_wdata = s.ctx_ccr;
        endcase
        if (s.cnt == FRAME_LAST) begin
          n.st  = ST_START;
          n.cnt = '0;
        end
      end
      ST_START: begin
        // Mask rises here, after the condition codes are on the stack
        n.imask = 1'b1;                                               // [RULE_08] [RULE_09]
        if (s.cnt == SETTLE_CNT) begin
          n.st       = ST_VEC_HI;
          n.mem_rd   = 1'b1;
          n.mem_addr = vec_addr(s.sc_s[1], s.vec, 1'b0);              // [RULE_01] [RULE_26]
        end else begin
          n.cnt = s.cnt + 3'h1;
        end
      end
      ST_VEC_HI: begin
        n.st       = ST_VEC_LO;
        n.mem_rd   = 1'b1;
        n.mem_addr = vec_addr(s.sc_s[1], s.vec, 1'b1);                // [RULE_26]
      end
      ST_VEC_LO: begin
        n.st     = ST_LOAD;
        n.vec_hi = MEM_RDATA;                                         // [RULE_26]
      end
      ST_LOAD: begin
        n.st         = ST_IDLE;
        n.handler    = {s.vec_hi, MEM_RDATA};
        n.handler_v  = 1'b1;
        n.first_wait = 1'b1;
      end
      default: n.st = ST_IDLE;
    endcase

    // Pin reset and watchdog restart the core like power-on
    if (soft_rst) begin
      n.st         = ST_START;                                        // [RULE_02]
      n.cnt        = '0;
      n.vec        = VEC_RESET;
      n.sp         = SP_TOP;                                          // [RULE_15]
      n.imask      = 1'b1;                                            // [RULE_08]
      n.flag_a     = 1'b0;
      n.flag_b     = 1'b0;
      n.kw_latch   = '0;
      n.en_a       = 1'b0;
      n.en_b       = 1'b0;
      n.en_kw      = 1'b0;
      n.sel_a      = 1'b0;
      n.sel_b      = 1'b0;
      n.eff_a      = 1'b0;
      n.eff_b      = 1'b0;
      n.eff_kw     = 1'b0;
      n.src_en     = '0;
      n.key_wakeup_input_enables      = '0;
      n.swi_blk    = 1'b0;
      n.first_wait = 1'b0;
      n.mem_we     = 1'b0;
      n.mem_rd     = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= RESET_VAL;
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign RDATA         = s.rdata;
  assign BUSY          = s.st != ST_IDLE;
  assign IMASK         = s.imask;
  assign STACK_ADDR    = {SP_UPPER, s.sp};                            // [RULE_16]
  assign HANDLER_PC    = s.handler;
  assign HANDLER_VALID = s.handler_v;
  assign EXT_A_LEVEL   = line_a;                                      // [RULE_19]
  assign PORT_C_LEVELS = {line_a, line_b};                            // [RULE_19]
  assign MEM_ADDR      = s.mem_addr;
  assign MEM_WDATA     = s.mem_wdata;
  assign MEM_WE        = s.mem_we;
  assign MEM_RD        = s.mem_rd;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence five_writes_s;
    MEM_WE [*5];
  endsequence

  sequence pc_bytes_s;
    (MEM_WDATA == s.ctx_pc[7:0]) ##1 (MEM_WDATA == s.ctx_pc[15:8]);
  endsequence

  frame_length_a: assert property ((s.st == ST_IDLE && (take_swi || take_hw)) |=> // [RULE_14]
      ##1 five_writes_s ##1 !MEM_WE)
    else $error("interrupt frame is not five bytes");
  frame_order_a: assert property ((s.st == ST_IDLE && (take_swi || take_hw)) |=> ##1 pc_bytes_s) // [RULE_14]
    else $error("program counter bytes pushed in wrong order");
  mask_after_push_a: assert property ((s.st == ST_IDLE && take_hw && !IMASK_SET) |=> // [RULE_09]
      (!s.imask) [*5] ##2 s.imask)
    else $error("global mask set at the wrong time");
  vector_pair_a: assert property ((s.st == ST_VEC_HI) |-> (MEM_RD && !MEM_ADDR[0]) // [RULE_26]
      ##1 (MEM_RD && MEM_ADDR[0]))
    else $error("vector bytes fetched out of order");
  global_mask_a: assert property (s.imask |-> !INT_PENDING) // [RULE_11]
    else $error("request passed the global mask");
  trap_entry_a: assert property (take_swi |=> (s.st == ST_PUSH && s.vec == VEC_SWI)) // [RULE_03]
    else $error("software trap not entered");
  pin_priority_a: assert property ((take_hw && cls[VEC_EXT]) |=> s.vec == VEC_EXT) // [RULE_10]
    else $error("pin request lost priority");
  sp_wrap_a: assert property ((STACK_PUSH && !STACK_POINTER_RESET_INSTR && s.st == ST_IDLE && // [RULE_16]
      !soft_rst && s.sp == '0) |=> s.sp == SP_TOP)
    else $error("stack pointer did not wrap");
  key_clear_a: assert property ((clr_kw && kw_fall == '0 && !soft_rst) |=> s.kw_latch == '0) // [RULE_21]
    else $error("key latches not cleared together");
  flag_hold_a: assert property ((s.flag_a && !clr_a && !soft_rst) |=> s.flag_a) // [RULE_27]
    else $error("pin flag dropped without a clear");
  reset_vector_a: assert property ((soft_rst) |=> (s.imask && s.vec == VEC_RESET)) // [RULE_02]
    else $error("reset did not select top vector");

endmodule : interrupt_priority_stacking

/* sim/mem_partner.sv */
`timescale 1ns/1ps
module mem_partner (
  // Clock
  input  wire logic        CLK,
  // Memory port
  input  wire logic [15:0] MEM_ADDR,
  input  wire logic [7:0]  MEM_WDATA,
  input  wire logic        MEM_WE,
  input  wire logic        MEM_RD,
  output logic      [7:0]  MEM_RDATA
);
  // ------------------------------------------------------------
  // Stack capture and vector bytes
  // ------------------------------------------------------------
  logic [7:0] stack_mem [256];
  logic       high_bad  = 1'b0;
  initial MEM_RDATA = 8'h5a;
  always @(posedge CLK) begin
    if (MEM_WE) begin
      stack_mem[MEM_ADDR[7:0]] <= MEM_WDATA;
      if (MEM_ADDR[15:8] != 8'h00) high_bad <= 1'b1;
    end
    // Data valid one cycle only; toggles otherwise so stale bytes never match
    if (MEM_RD) MEM_RDATA <= MEM_ADDR[0] ? MEM_ADDR[7:0] : {4'ha, MEM_ADDR[3:0]};
    else MEM_RDATA <= ~MEM_RDATA;
  end
endmodule : mem_partner

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import irq_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        CLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, SELF_CHECK = 1'b0;
  logic [7:0]  ADDR = 8'h00, WDATA = 8'h00, KEY_WAKEUP_N = 8'hff, RDATA, MEM_RDATA, MEM_WDATA;
  logic        EXT_REQUEST_A_N = 1'b1, EXT_REQUEST_B_N = 1'b1, EXT_RESET_N = 1'b1, WATCHDOG_TIMEOUT = 1'b0;
  logic [1:0]  PORT_C_LATCH = 2'b11, PORT_C_LEVELS;
  logic [6:0]  src = 7'h00;
  logic        INSTR_DONE = 1'b0, SOFTWARE_TRAP = 1'b0, STACK_PUSH = 1'b0, STACK_PULL = 1'b0;
  logic        STACK_POINTER_RESET_INSTR = 1'b0, IMASK_SET = 1'b0, IMASK_CLEAR = 1'b0;
  logic [15:0] PC_IN = 16'h1234, STACK_ADDR, HANDLER_PC, MEM_ADDR;
  logic [7:0]  ACC_IN = 8'h56, INDEX_IN = 8'h78;
  logic [3:0]  CCR_FLAGS = 4'ha;
  logic        BUSY, INT_PENDING, IMASK, HANDLER_VALID, EXT_A_LEVEL, MEM_WE, MEM_RD;
  int          err_total = 0, tests_run = 0, cyc = 0;
  always #2 CLK = ~CLK;
  interrupt_priority_stacking interrupt_priority_stacking_inst (
    .CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .EXT_REQUEST_A_N, .EXT_REQUEST_B_N, .KEY_WAKEUP_N,
    .EXT_RESET_N, .SELF_CHECK, .PORT_C_LATCH, .WATCHDOG_TIMEOUT,
    .TIMER_A_OVERFLOW_IRQ(src[0]), .TIMER_A_CAPTURE_IRQ(src[1]), .TIMER_A_COMPARE_IRQ(src[2]),
    .TIMER_B_IRQ(src[3]), .TIMER_B_COMPARE_IRQ(src[4]), .SERIAL_TRANSFER_IRQ(src[5]), .TIMEBASE_IRQ(src[6]),
    .INSTR_DONE, .SOFTWARE_TRAP, .STACK_PUSH, .STACK_PULL, .STACK_POINTER_RESET_INSTR, .IMASK_SET,
    .IMASK_CLEAR, .PC_IN, .ACC_IN, .INDEX_IN, .CCR_FLAGS, .BUSY, .INT_PENDING, .IMASK, .STACK_ADDR,
    .HANDLER_PC, .HANDLER_VALID, .EXT_A_LEVEL, .PORT_C_LEVELS, .MEM_ADDR, .MEM_WDATA, .MEM_WE, .MEM_RD,
    .MEM_RDATA);
  mem_partner mem_partner_inst (.CLK, .MEM_ADDR, .MEM_WDATA, .MEM_WE, .MEM_RD, .MEM_RDATA);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge CLK);
  endtask : tick
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Strobes drop with a gap cycle so no signal is driven twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    ADDR <= a; WDATA <= v; WR <= 1'b1;
    tick();
    WR <= 1'b0;
    tick();
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    ADDR <= a; RD <= 1'b1;
    tick();
    RD <= 1'b0;
    #1 chk("rdata", {8'h00, RDATA}, {8'h00, exp});
    tick();
  endtask : rd_chk
  task automatic pulse(input int which);
    case (which)
      0: INSTR_DONE <= 1'b1;
      1: SOFTWARE_TRAP <= 1'b1;
      2: IMASK_CLEAR <= 1'b1;
      default: WATCHDOG_TIMEOUT <= 1'b1;
    endcase
    tick();
    {INSTR_DONE, SOFTWARE_TRAP, IMASK_CLEAR, WATCHDOG_TIMEOUT} <= 4'h0;
    tick();
  endtask : pulse
  function automatic logic [15:0] vec_pc(input logic [15:0] base, input logic [2:0] v);
    logic [15:0] a;
    a = base + {12'h000, v, 1'b0};
    return {4'ha, a[3:0], a[7:0] + 8'h01};
  endfunction : vec_pc
  task automatic wait_hv(input logic [15:0] exp);
    int n;
    n = 0;
    do begin tick(); #1; n++; end while (HANDLER_VALID !== 1'b1 && n < 40);
    chk("handler valid", {15'h0, HANDLER_VALID}, 16'h0001);
    chk("handler pc", HANDLER_PC, exp);
    tick();
  endtask : wait_hv
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    wait_hv(vec_pc(VEC_BASE_USER, VEC_RESET));
    chk("imask", {15'h0, IMASK}, 16'h0001);
    chk("busy", {15'h0, BUSY}, 16'h0000);
    chk("sp", STACK_ADDR, 16'h00ff);
    rd_chk(OFF_CORE, 8'hbf);
    rd_chk(8'h07, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ext_a();
    logic [7:0] stk [5];
    stk = '{8'h34, 8'h12, 8'h78, 8'h56, 8'hf2};
    pulse(2);
    wr(OFF_CTRL, 8'h00);
    EXT_REQUEST_A_N <= 1'b0;
    tick(5);
    chk("ext a level", {15'h0, EXT_A_LEVEL}, 16'h0000);
    chk("port c", {14'h0, PORT_C_LEVELS}, 16'h0001);
    rd_chk(OFF_STATUS, 8'h80);
    chk("pending off", {15'h0, INT_PENDING}, 16'h0000);
    wr(OFF_CTRL, 8'h80);
    chk("pending late", {15'h0, INT_PENDING}, 16'h0000);
    pulse(0);
    chk("pending on", {15'h0, INT_PENDING}, 16'h0001);
    pulse(0);
    wait_hv(vec_pc(VEC_BASE_USER, VEC_EXT));
    for (int i = 0; i < 5; i++) chk("stack", {8'h0, mem_partner_inst.stack_mem[8'hff - i]}, {8'h0, stk[i]});
    chk("sp after", STACK_ADDR, 16'h00fa);
    chk("imask set", {15'h0, IMASK}, 16'h0001);
    chk("stack page", {15'h0, mem_partner_inst.high_bad}, 16'h0000);
    EXT_REQUEST_A_N <= 1'b1;
    tick(5);
    wr(OFF_STATUS, 8'h00);
    rd_chk(OFF_STATUS, 8'h80);
    wr(OFF_STATUS, 8'h08);
    rd_chk(OFF_STATUS, 8'h00);
    wr(OFF_CTRL, 8'h00);
    $display("test ext a done");
  endtask : t_ext_a
  task automatic t_periph();
    logic [2:0] vt [7];
    vt = '{VEC_TIMER_A, VEC_TIMER_A, VEC_TIMER_A, VEC_TIMER_B, VEC_TIMER_B, VEC_SERIAL, VEC_TIMEBASE};
    for (int i = 0; i < 7; i++) begin
      wr(OFF_SRCEN, 8'h01 << i);
      src <= 7'h01 << i;
      tick(2);
      chk("masked", {15'h0, INT_PENDING}, 16'h0000);
      pulse(2);
      chk("unmasked", {15'h0, INT_PENDING}, 16'h0001);
      pulse(0);
      wait_hv(vec_pc(VEC_BASE_USER, vt[i]));
      src <= 7'h00;
    end
    wr(OFF_SRCEN, 8'h40);
    src <= 7'h01;
    pulse(2);
    chk("source mask", {15'h0, INT_PENDING}, 16'h0000);
    wr(OFF_SRCEN, 8'h41);
    src <= 7'h41;
    pulse(0);
    wait_hv(vec_pc(VEC_BASE_USER, VEC_TIMER_A));
    src <= 7'h00;
    $display("test peripherals done");
  endtask : t_periph
  task automatic t_trap();
    pulse(1);
    wait_hv(vec_pc(VEC_BASE_USER, VEC_SWI));
    chk("trap mask", {15'h0, IMASK}, 16'h0001);
    $display("test trap done");
  endtask : t_trap
  task automatic t_key();
    wr(OFF_KEY_WAKEUP_INPUT_ENABLES, 8'h01);
    KEY_WAKEUP_N <= 8'hfd;
    tick(5);
    rd_chk(OFF_STATUS, 8'h00);
    KEY_WAKEUP_N <= 8'hfc;
    tick(5);
    rd_chk(OFF_STATUS, 8'h10);
    KEY_WAKEUP_N <= 8'hff;
    wr(OFF_STATUS, 8'h01);
    rd_chk(OFF_STATUS, 8'h00);
    wr(OFF_CTRL, 8'h04);
    PORT_C_LATCH <= 2'b10;
    tick(5);
    rd_chk(OFF_STATUS, 8'h40);
    wr(OFF_STATUS, 8'h04);
    rd_chk(OFF_STATUS, 8'h00);
    PORT_C_LATCH <= 2'b11;
    wr(OFF_CTRL, 8'h00);
    $display("test key done");
  endtask : t_key
  task automatic t_self();
    SELF_CHECK <= 1'b1;
    tick(4);
    pulse(3);
    wait_hv(vec_pc(VEC_BASE_CHECK, VEC_RESET));
    chk("sp reset", STACK_ADDR, 16'h00ff);
    STACK_PUSH <= 1'b1;
    tick();
    STACK_PUSH <= 1'b0;
    tick();
    chk("sp push", STACK_ADDR, 16'h00fe);
    STACK_PULL <= 1'b1;
    tick();
    STACK_PULL <= 1'b0;
    tick();
    chk("sp pull", STACK_ADDR, 16'h00ff);
    $display("test self check done");
  endtask : t_self
  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    tick(10);
    RST <= 1'b0;
    t_reset();
    t_ext_a();
    t_periph();
    t_trap();
    t_key();
    t_self();
    summarize();
  end
endmodule : tb_top
